/* verilog/mor_pkg.sv */
// package: register map, field layout and timing of the muting supervisor
package mor_pkg;
   // ***************************************************************
   // timing
   // ***************************************************************
   localparam int CLK_PERIOD_PS = 5000;
   localparam int MS_PS = 1000000000;
   localparam int MS_CYCLES_DEF = (MS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int S_MS = 1000;
   localparam int MIN_MS = 60000;
   localparam int PAIR_LIM = 1000;
   localparam int FILT_MAX = 1000;
   localparam int DLY_MAX = 1000;
   localparam int TEACH_MIN = 500;
   localparam int TEACH_MAX = 4000;
   localparam logic [2:0] TOL_MAX = 3'h6;
   // ***************************************************************
   // register map (byte addresses) and fields
   // ***************************************************************
   localparam int AW = 6;
   localparam logic [AW-1:0] A_CTRL = 6'h00;
   localparam logic [AW-1:0] A_MUTE = 6'h04;
   localparam logic [AW-1:0] A_DLY = 6'h08;
   localparam logic [AW-1:0] A_FILT = 6'h0C;
   localparam logic [AW-1:0] A_DYN = 6'h10;
   localparam logic [AW-1:0] A_OVR = 6'h14;
   localparam logic [AW-1:0] A_ZONE = 6'h18;
   localparam logic [AW-1:0] A_BLANK = 6'h1C;
   localparam logic [AW-1:0] A_STAT = 6'h20;
   localparam logic [AW-1:0] A_ISTAT = 6'h24;
   localparam logic [AW-1:0] A_IMASK = 6'h28;
   localparam int C_MANUAL = 0;
   localparam int C_CODE = 1;
   localparam int C_FB_CHECK = 3;
   localparam int C_MUTE = 4;
   localparam int C_BLANK = 5;
   localparam int C_RRES = 6;
   localparam int C_STOPCLR = 7;
   localparam int C_DYN = 8;
   localparam int C_TOP = 9;
   localparam int C_LAMP = 10;
   localparam int C_EDGE = 11;
   localparam int C_4S = 12;
   localparam int M_MULT = 0;
   localparam int M_TMAX = 8;
   localparam int M_TMIN = 16;
   localparam int F_ACT = 0;
   localparam int F_DEACT = 16;
   localparam int D_TEACH = 0;
   localparam int D_TOL = 16;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] MUTE_RST = 32'h0064_0301;
   localparam logic [31:0] DYN_RST = 32'h0000_07D0;
   localparam logic [31:0] OVR_RST = 32'h0000_0001;
   // ***************************************************************
   // sync slots, events, states
   // ***************************************************************
   localparam int I_M1 = 0;
   localparam int I_M2 = 1;
   localparam int I_O1 = 2;
   localparam int I_O2 = 3;
   localparam int I_RS = 4;
   localparam int I_FB = 5;
   localparam int I_LAMP = 6;
   localparam int NEV = 8;
   localparam int E_MSTART = 0;
   localparam int E_MEND = 1;
   localparam int E_PAIR = 2;
   localparam int E_MTO = 3;
   localparam int E_LAMP = 4;
   localparam int E_OSTART = 5;
   localparam int E_OEND = 6;
   localparam int E_LOCK = 7;
   typedef enum logic [2:0] {
      ST_RUN, ST_WAIT2, ST_MUTED, ST_DELAY, ST_OVR, ST_LOCK
   } mor_st_e;
endpackage

/* verilog/mor_mute_ctrl.sv */
// muting, blanking and override supervisor with avalon-mm registers
//
// Design decisions made here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - muting time limit is multiplier (1..16, default 2) times measured pair interval
// - muting stops on sensor release only, or also on a clear curtain
// - pair interval below configured minimum (default 100 ms) is a fault
// - pair interval above configured maximum (1..16 s, default 4) is a fault
// - muting extends by delay time 0..1000 ms after sequence end
// - muting inputs filtered 0..1000 ms before counting as released
// - muting inputs filtered 0..1000 ms before counting as active
// - dynamic muting narrows to taught material height after teach time
// - dynamic muting tolerates 0..6 extra beams above taught height
// - start-from-top reverses beam order for dynamic muting
// - optional lamp check faults muting when the lamp is absent
// - level override needs both override inputs held throughout
// - edge override starts on edge and runs without held inputs
// - automatic restart keeps outputs high after override ends
// - manual restart enters interlock after override, awaits restart
// - restart mode, coding and contactor feedback check are settable
// - function select muting, blanking or both, plus reduced resolution
// - beams grouped into a zone that muting covers; blanking uses its own beam mask
module mor_mute_ctrl #(
   parameter int BEAMS = 16,
   parameter int MS_CYCLES = mor_pkg::MS_CYCLES_DEF,
   parameter int PAIR_MIN_LO = 10
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   // avalon-mm slave
   input wire logic [mor_pkg::AW-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   output logic irq_o,
   // field inputs, asynchronous
   input wire logic mute1_i,
   input wire logic mute2_i,
   input wire logic ovr1_i,
   input wire logic ovr2_i,
   input wire logic restart_i,
   input wire logic contactor_feedback_check_i,
   input wire logic lamp_ok_i,
   // optical front end, same clock
   input wire logic [BEAMS-1:0] beam_blocked_i,
   // safety and status outputs
   output logic safe_o,
   output logic mute_lamp_o,
   output logic ovr_status_o,
   output logic [1:0] coding_o
);
   import mor_pkg::*;

   localparam int TW = $clog2(MS_CYCLES);
   localparam int HW = $clog2(BEAMS);

   if (BEAMS < 2 || BEAMS > 32 || MS_CYCLES < 2 ||
       PAIR_MIN_LO < 0 || PAIR_MIN_LO > PAIR_LIM) begin : g_bad
      $error("mor_mute_ctrl: unsupported parameter value");
   end

   typedef struct packed {
      logic [6:0] sy1;
      logic [6:0] sy2;
      logic rst_q;
      logic ovr_q;
      logic [TW-1:0] div;
      logic tick;
      logic [1:0][9:0] fcnt;
      logic [1:0] filt;
      mor_st_e st;
      logic [23:0] cnt;
      logic [13:0] pair;
      logic [11:0] teach;
      logic tdone;
      logic occ;
      logic [HW-1:0] height;
      logic safe;
      logic [31:0] ctrl;
      logic [31:0] mute;
      logic [31:0] dly;
      logic [31:0] filtc;
      logic [31:0] dyn;
      logic [31:0] ovrc;
      logic [BEAMS-1:0] zone;
      logic [BEAMS-1:0] blank;
      logic [NEV-1:0] ist;
      logic [NEV-1:0] imsk;
      logic ack;
      logic [31:0] rdata;
   } mor_state_s;

   mor_state_s q;
   mor_state_s next_q;

   // decoded terms, also watched by the checks below
   logic both;
   logic any;
   logic clear;
   logic intr;
   logic lamp_bad;
   logic ovr_both;
   logic ovr_fin;
   logic otime;
   logic [15:0] pair_min;
   logic [15:0] pair_max;
   logic [15:0] dlyms;
   logic [23:0] lim;
   logic req;

   // ***************************************************************
   // helpers
   // ***************************************************************
   function automatic logic [15:0] clampv(input logic [15:0] v,
      input logic [15:0] lo, input logic [15:0] hi);
      clampv = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   function automatic logic [BEAMS-1:0] rev(input logic [BEAMS-1:0] v);
      for (int i = 0; i < BEAMS; i++) begin
         rev[i] = v[BEAMS-1-i];
      end
   endfunction

   function automatic logic [5:0] popc(input logic [BEAMS-1:0] v);
      popc = '0;
      for (int i = 0; i < BEAMS; i++) begin
         popc = popc + 6'(v[i]);
      end
   endfunction

   function automatic logic [HW-1:0] topi(input logic [BEAMS-1:0] v);
      topi = '0;
      for (int i = 0; i < BEAMS; i++) begin
         if (v[i]) begin
            topi = HW'(i);
         end
      end
   endfunction

   function automatic logic [BEAMS-1:0] lowm(input logic [5:0] h);
      for (int i = 0; i < BEAMS; i++) begin
         lowm[i] = (6'(i) <= h);
      end
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] o,
      input logic [31:0] w, input logic [3:0] be);
      for (int i = 0; i < 4; i++) begin
         merge[8*i +: 8] = be[i] ? w[8*i +: 8] : o[8*i +: 8];
      end
   endfunction

   // ***************************************************************
   // next state
   // ***************************************************************
   always_comb begin
      logic [BEAMS-1:0] ord;
      logic [BEAMS-1:0] mmask;
      logic [BEAMS-1:0] eff;
      logic [15:0] fth;
      logic [15:0] tch;
      logic [15:0] lo;
      logic [23:0] olim;
      logic [2:0] tol;
      logic [NEV-1:0] ev;
      logic [31:0] wm;
      logic ovr_go;
      logic fb_ok;
      logic rs_rise;
      logic fault;
      ord = '0;
      mmask = '0;
      eff = '0;
      fth = '0;
      tch = '0;
      lo = '0;
      olim = '0;
      tol = '0;
      ev = '0;
      wm = '0;
      fault = 1'b0;
      ovr_go = 1'b0;
      fb_ok = 1'b0;
      rs_rise = 1'b0;
      next_q = q;
      next_q.sy1 = {lamp_ok_i, contactor_feedback_check_i, restart_i,
                    ovr2_i, ovr1_i, mute2_i, mute1_i};
      next_q.sy2 = q.sy1;
      next_q.rst_q = q.sy2[I_RS];
      ovr_both = q.sy2[I_O1] & q.sy2[I_O2];
      next_q.ovr_q = ovr_both;
      rs_rise = q.sy2[I_RS] & ~q.rst_q;
      fb_ok = ~q.ctrl[C_FB_CHECK] | q.sy2[I_FB];
      // millisecond time base
      next_q.tick = 1'b0;
      if (q.div == TW'(MS_CYCLES - 1)) begin
         next_q.div = '0;
         next_q.tick = 1'b1;
      end else begin
         next_q.div = q.div + TW'(1);
      end
      // a change only counts once the new level has held the filter time
      for (int k = 0; k < 2; k++) begin
         fth = q.sy2[k] ?
            clampv(16'(q.filtc[F_ACT +: 10]), '0, 16'(FILT_MAX)) :
            clampv(16'(q.filtc[F_DEACT +: 10]), '0, 16'(FILT_MAX));
         if (q.sy2[k] == q.filt[k]) begin
            next_q.fcnt[k] = '0;
         end else if (16'(q.fcnt[k]) >= fth) begin
            next_q.filt[k] = q.sy2[k];
            next_q.fcnt[k] = '0;
         end else if (q.tick) begin
            next_q.fcnt[k] = q.fcnt[k] + 10'd1;
         end
      end
      both = q.filt[0] & q.filt[1];
      any = q.filt[0] | q.filt[1];
      // configuration, clamped to the legal ranges at use
      lo = q.ctrl[C_4S] ? '0 : 16'(PAIR_MIN_LO);
      pair_min = clampv(16'(q.mute[M_TMIN +: 10]), lo, 16'(PAIR_LIM));
      pair_max = (16'(q.mute[M_TMAX +: 4]) + 16'd1) * 16'(S_MS);
      lim = 24'({1'b0, q.mute[M_MULT +: 4]} + 5'd1) * 24'(q.pair);
      dlyms = clampv(16'(q.dly[9:0]), '0, 16'(DLY_MAX));
      tch = clampv(16'(q.dyn[D_TEACH +: 12]), 16'(TEACH_MIN),
                   16'(TEACH_MAX));
      tol = (q.dyn[D_TOL +: 3] > TOL_MAX) ? TOL_MAX : q.dyn[D_TOL +: 3];
      olim = 24'({1'b0, q.ovrc[7:0]} + 9'd1) * 24'(MIN_MS);
      // beam evaluation
      ord = q.ctrl[C_TOP] ? rev(beam_blocked_i) : beam_blocked_i;
      clear = ~|beam_blocked_i;
      eff = beam_blocked_i;
      if (q.ctrl[C_BLANK]) begin
         eff = eff & ~q.blank;
      end
      mmask = '1;
      if (q.ctrl[C_DYN] && q.tdone) begin
         mmask = lowm(6'(q.height) + 6'(tol));
         mmask = q.ctrl[C_TOP] ? rev(mmask) : mmask;
      end
      mmask = mmask & q.zone;
      if (q.st == ST_MUTED || q.st == ST_DELAY) begin
         eff = eff & ~mmask;
      end
      // reduced resolution lets one isolated interrupted beam pass
      intr = q.ctrl[C_RRES] ? (popc(eff) > 6'd1) : |eff;
      lamp_bad = q.ctrl[C_LAMP] & ~q.sy2[I_LAMP];
      ovr_go = q.ctrl[C_EDGE] ? (ovr_both & ~q.ovr_q) : ovr_both;
      otime = (q.cnt >= olim);
      // level mode ends the moment either input drops
      ovr_fin = clear | (~q.ctrl[C_EDGE] & ~ovr_both);
      // ***************************************************************
      // sequence
      // ***************************************************************
      case (q.st)
         ST_RUN: begin
            next_q.safe = ~intr;
            if (ovr_go && intr) begin
               next_q.st = ST_OVR;
               next_q.cnt = '0;
               ev[E_OSTART] = 1'b1;
            end else if (intr && q.ctrl[C_MANUAL]) begin
               fault = 1'b1;
            end else if (q.ctrl[C_MUTE] && any) begin
               next_q.st = ST_WAIT2;
               next_q.cnt = '0;
            end
         end
         ST_WAIT2: begin
            next_q.safe = ~intr;
            if (q.tick) begin
               next_q.cnt = q.cnt + 24'd1;
            end
            if (intr && q.ctrl[C_MANUAL]) begin
               fault = 1'b1;
            end else if (both) begin
               if (q.cnt >= 24'(pair_min)) begin
                  next_q.st = ST_MUTED;
                  next_q.pair = q.cnt[13:0];
                  next_q.cnt = '0;
                  next_q.teach = '0;
                  next_q.tdone = 1'b0;
                  next_q.occ = 1'b0;
                  next_q.height = '0;
                  ev[E_MSTART] = 1'b1;
               end else begin
                  fault = 1'b1;
                  ev[E_PAIR] = 1'b1;
               end
            end else if (!any) begin
               next_q.st = ST_RUN;
            end else if (q.cnt > 24'(pair_max)) begin
               fault = 1'b1;
               ev[E_PAIR] = 1'b1;
            end
         end
         ST_MUTED: begin
            next_q.safe = ~intr;
            if (q.tick) begin
               next_q.cnt = q.cnt + 24'd1;
            end
            next_q.occ = q.occ | ~clear;
            // teach: remember the highest interrupted beam
            if (q.ctrl[C_DYN] && !q.tdone) begin
               if (|ord && topi(ord) > q.height) begin
                  next_q.height = topi(ord);
               end
               if (16'(q.teach) >= tch) begin
                  next_q.tdone = 1'b1;
               end else if (q.tick) begin
                  next_q.teach = q.teach + 12'd1;
               end
            end
            if (lamp_bad) begin
               fault = 1'b1;
               ev[E_LAMP] = 1'b1;
            end else if (q.cnt >= lim) begin
               fault = 1'b1;
               ev[E_MTO] = 1'b1;
            end else if (q.ctrl[C_STOPCLR] && q.occ && clear) begin
               next_q.st = ST_RUN;
               ev[E_MEND] = 1'b1;
            end else if (!any) begin
               next_q.st = ST_DELAY;
               next_q.cnt = '0;
            end
         end
         ST_DELAY: begin
            next_q.safe = ~intr;
            if (q.cnt >= 24'(dlyms)) begin
               next_q.st = ST_RUN;
               ev[E_MEND] = 1'b1;
            end else if (q.tick) begin
               next_q.cnt = q.cnt + 24'd1;
            end
         end
         ST_OVR: begin
            next_q.safe = 1'b1;
            if (q.tick) begin
               next_q.cnt = q.cnt + 24'd1;
            end
            if (lamp_bad) begin
               fault = 1'b1;
               ev[E_LAMP] = 1'b1;
            end else if (otime) begin
               fault = 1'b1;
               ev[E_OEND] = 1'b1;
            end else if (ovr_fin) begin
               ev[E_OEND] = 1'b1;
               if (q.ctrl[C_MANUAL]) begin
                  fault = 1'b1;
               end else begin
                  next_q.st = ST_RUN;
               end
            end
         end
         ST_LOCK: begin
            next_q.safe = 1'b0;
            if (ovr_go && intr) begin
               next_q.st = ST_OVR;
               next_q.cnt = '0;
               ev[E_OSTART] = 1'b1;
            end else if (rs_rise && !intr && fb_ok) begin
               next_q.st = ST_RUN;
            end
         end
         default: begin
            fault = 1'b1;
         end
      endcase
      if (fault) begin
         next_q.st = ST_LOCK;
         next_q.safe = 1'b0;
         ev[E_LOCK] = 1'b1;
      end
      // ***************************************************************
      // register slave: one wait state, then the answer
      // ***************************************************************
      req = avs_read_i | avs_write_i;
      next_q.ack = req & ~q.ack;
      if (req && !q.ack) begin
         case (avs_address_i)
            A_CTRL: next_q.rdata = q.ctrl;
            A_MUTE: next_q.rdata = q.mute;
            A_DLY: next_q.rdata = q.dly;
            A_FILT: next_q.rdata = q.filtc;
            A_DYN: next_q.rdata = q.dyn;
            A_OVR: next_q.rdata = q.ovrc;
            A_ZONE: next_q.rdata = 32'(q.zone);
            A_BLANK: next_q.rdata = 32'(q.blank);
            A_STAT: next_q.rdata = 32'({q.height, q.tdone, q.safe, q.st});
            A_ISTAT: next_q.rdata = 32'(q.ist);
            A_IMASK: next_q.rdata = 32'(q.imsk);
            default: next_q.rdata = '0;
         endcase
      end
      if (avs_write_i && q.ack) begin
         case (avs_address_i)
            A_CTRL: next_q.ctrl = merge(q.ctrl, avs_writedata_i,
                                        avs_byteenable_i);
            A_MUTE: next_q.mute = merge(q.mute, avs_writedata_i,
                                        avs_byteenable_i);
            A_DLY: next_q.dly = merge(q.dly, avs_writedata_i,
                                      avs_byteenable_i);
            A_FILT: next_q.filtc = merge(q.filtc, avs_writedata_i,
                                         avs_byteenable_i);
            A_DYN: next_q.dyn = merge(q.dyn, avs_writedata_i,
                                      avs_byteenable_i);
            A_OVR: next_q.ovrc = merge(q.ovrc, avs_writedata_i,
                                       avs_byteenable_i);
            A_ZONE: next_q.zone = BEAMS'(merge(32'(q.zone),
                        avs_writedata_i, avs_byteenable_i));
            A_BLANK: next_q.blank = BEAMS'(merge(32'(q.blank),
                        avs_writedata_i, avs_byteenable_i));
            A_ISTAT: wm = merge('0, avs_writedata_i, avs_byteenable_i);
            A_IMASK: next_q.imsk = NEV'(merge(32'(q.imsk),
                        avs_writedata_i, avs_byteenable_i));
            default: wm = '0;
         endcase
      end
      // a new event beats a clear in the same cycle
      next_q.ist = (q.ist & ~wm[NEV-1:0]) | ev;
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         q <= '0;
         q.st <= ST_RUN;
         q.ctrl <= CTRL_RST;
         q.mute <= MUTE_RST;
         q.dyn <= DYN_RST;
         q.ovrc <= OVR_RST;
         q.zone <= '1;
      end else begin
         q <= next_q;
      end
   end

   assign avs_waitrequest_o = req & ~q.ack;
   assign avs_readdata_o = q.rdata;
   assign irq_o = |(q.ist & q.imsk);
   assign safe_o = q.safe;
   assign mute_lamp_o = (q.st == ST_MUTED) || (q.st == ST_DELAY) ||
                        (q.st == ST_OVR);
   assign ovr_status_o = (q.st == ST_OVR);
   assign coding_o = q.ctrl[C_CODE +: 2];

   // ***************************************************************
   // checks
   // ***************************************************************
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);

   sequence ovr_manual_end;
      q.st == ST_OVR && q.ctrl[C_MANUAL] && ovr_fin && !lamp_bad && !otime;
   endsequence

   sequence locked_off;
      q.st == ST_LOCK && !safe_o;
   endsequence

   bus_ack_a: assert property (req && avs_waitrequest_o |=>
      !avs_waitrequest_o) else $error("bus request not answered");
   pair_short_a: assert property (
      q.st == ST_WAIT2 && both && q.cnt < 24'(pair_min) |=> locked_off)
      else $error("short pair interval not locked");
   pair_long_a: assert property (
      q.st == ST_WAIT2 && !both && any && q.cnt > 24'(pair_max) |=>
      q.st == ST_LOCK) else $error("long pair interval not locked");
   mute_limit_a: assert property (
      q.st == ST_MUTED && !lamp_bad && q.cnt >= lim |=> locked_off)
      else $error("muting limit not enforced");
   delay_end_a: assert property (
      q.st == ST_DELAY && q.cnt >= 24'(dlyms) |=> q.st == ST_RUN)
      else $error("muting delay overran");
   lamp_chk_a: assert property (
      q.st == ST_MUTED && lamp_bad |=> q.st == ST_LOCK)
      else $error("lamp failure ignored");
   ovr_level_a: assert property (
      q.st == ST_OVR && !q.ctrl[C_EDGE] && !ovr_both |=> q.st != ST_OVR)
      else $error("level override kept without inputs");
   ovr_edge_a: assert property (
      q.st == ST_OVR && q.ctrl[C_EDGE] && !clear && !lamp_bad && !otime
      |=> q.st == ST_OVR) else $error("edge override dropped");
   ovr_auto_a: assert property (
      q.st == ST_OVR && !q.ctrl[C_MANUAL] && ovr_fin && !lamp_bad &&
      !otime |=> q.st == ST_RUN && safe_o)
      else $error("auto restart lost outputs");
   ovr_manual_a: assert property (ovr_manual_end |=> locked_off)
      else $error("manual override end not interlocked");
   lock_off_a: assert property (q.st == ST_LOCK |-> !safe_o)
      else $error("outputs on in interlock");
endmodule
`default_nettype wire

/* dv/mor_field_model.sv */
// field side model: muting sensor pair and muting lamp
`timescale 1ns/1ps
`default_nettype none
module mor_field_model #(
   parameter int MSC = 10
) (
   // clock
   input wire logic clk_i,
   // commands from the bench
   input wire logic go_i,
   input wire logic stop_i,
   input wire logic [15:0] gap_ms_i,
   input wire logic lamp_fail_i,
   // field lines
   output logic mute1_o,
   output logic mute2_o,
   output logic lamp_ok_o
);
   int cnt = 0;
   // second sensor follows the first after the gap, both drop together
   always @(posedge clk_i) begin
      if (stop_i) begin
         mute1_o <= 1'h0;
         mute2_o <= 1'h0;
         cnt <= 0;
      end else if (go_i) begin
         mute1_o <= 1'h1;
         cnt <= 1;
      end else if (cnt > 0) begin
         cnt <= cnt + 1;
         mute2_o <= mute2_o | (cnt >= gap_ms_i * MSC);
      end
   end
   // lamp current present unless the bench breaks the lamp
   assign lamp_ok_o = ~lamp_fail_i;
endmodule
`default_nettype wire

/* dv/test_muting_override_controller.sv */
// testbench: register access, muting and override sequences
`timescale 1ns/1ps
`default_nettype none
module test_muting_override_controller;
   import mor_pkg::*;
   logic clk = 1'h0, nrst = 1'h0, rd = 1'h0, wr = 1'h0, go = 1'h0;
   logic stop = 1'h1, o1 = 1'h0, o2 = 1'h0, rs = 1'h0, fb = 1'h1, lf = 1'h0;
   logic m1, m2, lamp, wq, irq, safe, ml, ovs;
   logic [1:0] cod;
   logic [5:0] adr = 6'h00;
   logic [31:0] wd = 32'h0, rdat, v;
   logic [15:0] beams = 16'h0, gap = 16'h0;
   int errors = 0, check_count = 0;
   always #2.5 clk = ~clk;
   mor_mute_ctrl #(.MS_CYCLES(10)) mor_mute_ctrl_inst (
      .sys_clk_i(clk), .nrst_i(nrst), .avs_address_i(adr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
      .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
      .avs_waitrequest_o(wq), .irq_o(irq), .mute1_i(m1), .mute2_i(m2),
      .ovr1_i(o1), .ovr2_i(o2), .restart_i(rs),
      .contactor_feedback_check_i(fb), .lamp_ok_i(lamp),
      .beam_blocked_i(beams), .safe_o(safe),
      .mute_lamp_o(ml), .ovr_status_o(ovs), .coding_o(cod));
   mor_field_model #(.MSC(10)) mor_field_model_inst (
      .clk_i(clk), .go_i(go), .stop_i(stop), .gap_ms_i(gap),
      .lamp_fail_i(lf), .mute1_o(m1), .mute2_o(m2), .lamp_ok_o(lamp));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   // request held until waitrequest is sampled low at a rising edge
   task automatic bus(input logic w, input logic [5:0] a,
                      input logic [31:0] d);
      rd <= ~w;
      wr <= w;
      adr <= a;
      wd <= d;
      do @(posedge clk); while (wq !== 1'h0);
      v = rdat;
      rd <= 1'h0;
      wr <= 1'h0;
      @(posedge clk);
   endtask
   task automatic rc(input logic [5:0] a, input logic [31:0] m, e);
      bus(1'h0, a, 32'h0);
      chk(v & m, e);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic seq(input logic [15:0] g);
      gap <= g;
      stop <= 1'h0;
      go <= 1'h1;
      @(posedge clk);
      go <= 1'h0;
   endtask
   task automatic complete_run();
      if (errors == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge clk);
      errors++;
      complete_run();
   end
   initial begin
      cyc(20);
      nrst <= 1'h1;
      @(posedge clk);
      rc(A_MUTE, 32'hFFFFFFFF, MUTE_RST);
      rc(A_DYN, 32'hFFFFFFFF, DYN_RST);
      rc(A_FILT, 32'hFFFFFFFF, 32'h0);
      rc(A_DLY, 32'hFFFFFFFF, 32'h0);
      rc(6'h2C, 32'hFFFFFFFF, 32'h0);
      bus(1'h1, A_CTRL, 32'h16);
      chk({30'h0, cod}, 32'h3);
      bus(1'h1, A_IMASK, 32'h1);
      bus(1'h1, A_DLY, 32'h5);
      // good pair, then held past multiplier x interval
      seq(16'h0096);
      cyc(10);
      rc(A_STAT, 32'h7, 32'h1);
      cyc(1550);
      rc(A_STAT, 32'hF, 32'hA);
      chk({30'h0, ml, irq}, 32'h3);
      bus(1'h1, A_ISTAT, 32'h1);
      chk({31'h0, irq}, 32'h0);
      cyc(2600);
      rc(A_STAT, 32'h7, 32'h2);
      cyc(500);
      rc(A_STAT, 32'hF, 32'h5);
      rc(A_ISTAT, 32'h8, 32'h8);
      stop <= 1'h1;
      rs <= 1'h1;
      cyc(10);
      rs <= 1'h0;
      cyc(10);
      // pair closer than the minimum interval
      seq(16'h0014);
      cyc(260);
      rc(A_STAT, 32'hF, 32'h5);
      chk({31'h0, safe}, 32'h0);
      rc(A_ISTAT, 32'h4, 32'h4);
      stop <= 1'h1;
      rs <= 1'h1;
      cyc(10);
      rs <= 1'h0;
      cyc(10);
      rc(A_STAT, 32'hF, 32'h8);
      // good pair ended by release, then extended by the delay
      seq(16'h0096);
      cyc(1560);
      stop <= 1'h1;
      cyc(20);
      rc(A_STAT, 32'h7, 32'h3);
      cyc(60);
      rc(A_STAT, 32'h7, 32'h0);
      // level override over an intrusion, switches held by the operator
      beams <= 16'h0010;
      o1 <= 1'h1;
      o2 <= 1'h1;
      cyc(20);
      chk({30'h0, ovs, safe}, 32'h3);
      o1 <= 1'h0;
      cyc(20);
      chk({31'h0, ovs}, 32'h0);
      beams <= 16'h0;
      o2 <= 1'h0;
      cyc(10);
      chk({31'h0, safe}, 32'h1);
      // manual restart, edge override, contactor feedback watched
      fb <= 1'h0;
      bus(1'h1, A_CTRL, 32'h81F);
      beams <= 16'h0010;
      cyc(10);
      rc(A_STAT, 32'hF, 32'h5);
      o1 <= 1'h1;
      o2 <= 1'h1;
      cyc(10);
      o1 <= 1'h0;
      o2 <= 1'h0;
      cyc(20);
      chk({30'h0, ovs, safe}, 32'h3);
      beams <= 16'h0;
      cyc(10);
      rc(A_STAT, 32'hF, 32'h5);
      rs <= 1'h1;
      cyc(10);
      rs <= 1'h0;
      cyc(10);
      rc(A_STAT, 32'hF, 32'h5);
      fb <= 1'h1;
      rs <= 1'h1;
      cyc(10);
      rs <= 1'h0;
      cyc(10);
      rc(A_STAT, 32'hF, 32'h8);
      // broken lamp ends muting at once
      lf <= 1'h1;
      bus(1'h1, A_CTRL, 32'h416);
      bus(1'h1, A_MUTE, 32'h000A_0301);
      seq(16'h000C);
      cyc(150);
      rc(A_STAT, 32'hF, 32'h5);
      rc(A_ISTAT, 32'h10, 32'h10);
      stop <= 1'h1;
      lf <= 1'h0;
      rs <= 1'h1;
      cyc(10);
      rs <= 1'h0;
      cyc(10);
      // activation filter, then a second sensor that never comes
      bus(1'h1, A_ISTAT, 32'hFF);
      bus(1'h1, A_FILT, 32'h14);
      bus(1'h1, A_MUTE, 32'h000A_0001);
      seq(16'hFFFF);
      cyc(150);
      rc(A_STAT, 32'h7, 32'h0);
      cyc(100);
      rc(A_STAT, 32'h7, 32'h1);
      cyc(10050);
      rc(A_STAT, 32'hF, 32'h5);
      rc(A_ISTAT, 32'h4, 32'h4);
      complete_run();
   end
endmodule
`default_nettype wire
